// file: rtl/ceh_hash_unit.v
/*
 * hash unit of the data_copy_coprocessor: arbiter, byte intake, crc,
 * sha-1 padding, signature write-out and reference check.
 * assumes the granted channel drives the shared command and byte ports.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ceh_map.vh"
module ceh_hash_unit #(
   parameter CHANNELS = 4,
   parameter PRIO_W   = 2
) (
   input  wire                       clk_sys,
   input  wire                       resetn,
   input  wire [CHANNELS-1:0]        chReq,
   input  wire [CHANNELS*PRIO_W-1:0] chPrio,
   input  wire                       cmdUseSha,
   input  wire                       cmdCheck,
   input  wire [159:0]               refValue,
   input  wire                       dataValid,
   input  wire [7:0]                 dataByte,
   input  wire                       dataLast,
   output reg  [CHANNELS-1:0]        chGrant,
   output reg                        dataReady,
   output reg                        sigValid,
   output reg  [159:0]               sigData,
   output reg  [CHANNELS-1:0]        sigChan,
   output reg                        mismatchIrq
);
   reg [2:0]   state_q;
   reg         useSha_q;
   reg         check_q;
   reg [159:0] ref_q;
   reg [31:0]  crc_q;
   reg [511:0] blk_q;
   reg [159:0] h_q;
   reg [5:0]   cnt_q;
   reg [60:0]  msgLen_q;
   reg [63:0]  lenSh_q;
   reg [1:0]   padPh_q;
   reg         retPad_q;
   reg         final_q;
   reg         coreStart_q;
   reg [CHANNELS-1:0] win;
   reg [PRIO_W-1:0]   bestPrio;
   reg         padIns;
   reg [7:0]   padByte;
   reg [7:0]   insByte;
   reg         ins;
   integer     i;
   wire        coreDone;
   wire [159:0] coreOut;
   wire        accept;
   wire        launch;
   wire [159:0] result;

   // ****************************************************************
   // crc byte step
   // ****************************************************************
   // reflected form: lsb of the byte enters first, as ethernet does
   function [31:0] crcByte;
      input [31:0] c;
      input [7:0]  b;
      integer      n;
      reg [31:0]   x;
      begin
         x = c ^ {24'h00_0000, b};
         for (n = 0; n < 8; n = n + 1)
            x = x[0] ? ((x >> 1) ^ `CEH_CRC_POLY) : (x >> 1);
         crcByte = x;
      end
   endfunction

   // ****************************************************************
   // arbiter
   // ****************************************************************
   // highest programmed level wins; ties go to the lowest channel.
   // a low level channel can starve while higher-level ones keep asking.
   always @* begin
      win      = {CHANNELS{1'b0}};
      bestPrio = {PRIO_W{1'b0}};
      for (i = CHANNELS - 1; i >= 0; i = i - 1) begin
         if (chReq[i] && (win == {CHANNELS{1'b0}} ||
             chPrio[i*PRIO_W +: PRIO_W] >= bestPrio)) begin
            win      = {CHANNELS{1'b0}};
            win[i]   = 1'b1;
            bestPrio = chPrio[i*PRIO_W +: PRIO_W];
         end
      end
   end

   // ****************************************************************
   // byte source: channel data or generated padding
   // ****************************************************************
   always @* begin
      padIns  = 1'b0;
      padByte = 8'h00;
      if (!useSha_q) begin
         padIns = (cnt_q[1:0] != 2'b00);
      end else begin
         case (padPh_q)
            2'd0: begin
               padIns  = 1'b1;
               padByte = `CEH_PAD_MARK;
            end
            2'd1: padIns = (cnt_q != `CEH_LEN_POS);
            2'd2: begin
               padIns  = 1'b1;
               padByte = lenSh_q[63:56];
            end
            default: padIns = 1'b0;
         endcase
      end
   end

   assign accept = (state_q == `CEH_ST_LOAD) && dataValid && dataReady;
   always @* begin
      ins     = accept || ((state_q == `CEH_ST_PAD) && padIns);
      insByte = accept ? dataByte : padByte;
   end
   assign launch = ins && useSha_q && (cnt_q == `CEH_BLK_END);
   assign result = useSha_q ? h_q : {128'h0, ~crc_q};

   ceh_sha1_core u_sha (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .start   (coreStart_q),
      .blockIn (blk_q),
      .hIn     (h_q),
      .done    (coreDone),
      .hOut    (coreOut)
   );

   // ****************************************************************
   // sequencer
   // ****************************************************************
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_q     <= `CEH_ST_IDLE;
         useSha_q    <= 1'b0;
         check_q     <= 1'b0;
         ref_q       <= 160'h0;
         crc_q       <= `CEH_CRC_INIT;
         blk_q       <= 512'h0;
         h_q         <= 160'h0;
         cnt_q       <= 6'h0;
         msgLen_q    <= 61'h0;
         lenSh_q     <= 64'h0;
         padPh_q     <= 2'd0;
         retPad_q    <= 1'b0;
         final_q     <= 1'b0;
         coreStart_q <= 1'b0;
         chGrant     <= {CHANNELS{1'b0}};
         dataReady   <= 1'b0;
         sigValid    <= 1'b0;
         sigData     <= 160'h0;
         sigChan     <= {CHANNELS{1'b0}};
         mismatchIrq <= 1'b0;
      end else begin
         coreStart_q <= 1'b0;
         sigValid    <= 1'b0;
         mismatchIrq <= 1'b0;
         if (ins) begin
            cnt_q <= cnt_q + 6'd1;
            if (useSha_q)
               blk_q <= {blk_q[503:0], insByte};
            else
               crc_q <= crcByte(crc_q, insByte);
         end
         case (state_q)
            `CEH_ST_IDLE: begin
               if (chReq != {CHANNELS{1'b0}}) begin
                  chGrant   <= win;
                  useSha_q  <= cmdUseSha;
                  check_q   <= cmdCheck;
                  ref_q     <= refValue;
                  crc_q     <= `CEH_CRC_INIT;
                  h_q       <= {`CEH_SHA_H0, `CEH_SHA_H1, `CEH_SHA_H2,
                                `CEH_SHA_H3, `CEH_SHA_H4};
                  cnt_q     <= 6'h0;
                  msgLen_q  <= 61'h0;
                  padPh_q   <= 2'd0;
                  final_q   <= 1'b0;
                  dataReady <= 1'b1;
                  state_q   <= `CEH_ST_LOAD;
               end
            end
            `CEH_ST_LOAD: begin
               if (accept) begin
                  msgLen_q <= msgLen_q + 61'd1;
                  if (dataLast) begin
                     // the crc never sees the length; only sha-1 uses it
                     lenSh_q <= {msgLen_q + 61'd1, 3'b000};
                     padPh_q <= 2'd0;
                  end
                  if (launch) begin
                     dataReady   <= 1'b0;
                     coreStart_q <= 1'b1;
                     retPad_q    <= dataLast;
                     state_q     <= `CEH_ST_HASH;
                  end else if (dataLast) begin
                     dataReady <= 1'b0;
                     state_q   <= `CEH_ST_PAD;
                  end
               end
            end
            `CEH_ST_PAD: begin
               if (padIns) begin
                  if (padPh_q == 2'd0)
                     padPh_q <= 2'd1;
                  if (padPh_q == 2'd2)
                     lenSh_q <= {lenSh_q[55:0], 8'h00};
                  if (launch) begin
                     coreStart_q <= 1'b1;
                     retPad_q    <= 1'b1;
                     final_q     <= (padPh_q == 2'd2);
                     state_q     <= `CEH_ST_HASH;
                  end
               end else if (!useSha_q) begin
                  state_q <= `CEH_ST_DONE;
               end else begin
                  padPh_q <= 2'd2;
               end
            end
            `CEH_ST_HASH: begin
               if (coreDone) begin
                  h_q <= coreOut;
                  if (final_q) begin
                     state_q <= `CEH_ST_DONE;
                  end else if (retPad_q) begin
                     state_q <= `CEH_ST_PAD;
                  end else begin
                     dataReady <= 1'b1;
                     state_q   <= `CEH_ST_LOAD;
                  end
               end
            end
            `CEH_ST_DONE: begin
               sigValid <= 1'b1;
               sigData  <= result;
               sigChan  <= chGrant;
               // crc reference sits in the low word of the payload copy
               mismatchIrq <= check_q && (useSha_q ? (ref_q != result) :
                              (ref_q[31:0] != result[31:0]));
               chGrant <= {CHANNELS{1'b0}};
               state_q <= `CEH_ST_IDLE;
            end
            default: state_q <= `CEH_ST_IDLE;
         endcase
      end
   end
endmodule // ceh_hash_unit
`default_nettype wire

// file: include/ceh_map.vh
/*
 * constants of the copy engine hash unit: states, crc and sha-1 figures.
 * assumes inclusion by bare name from the rtl files.
 */
`ifndef CEH_MAP_VH
`define CEH_MAP_VH
// ****************************************************************
// states
// ****************************************************************
`define CEH_ST_IDLE 3'h0
`define CEH_ST_LOAD 3'h1
`define CEH_ST_PAD  3'h2
`define CEH_ST_HASH 3'h3
`define CEH_ST_DONE 3'h4
// ****************************************************************
// crc figures
// ****************************************************************
`define CEH_CRC_INIT 32'hFFFF_FFFF
`define CEH_CRC_POLY 32'hEDB8_8320
// ****************************************************************
// sha-1 figures
// ****************************************************************
`define CEH_SHA_H0   32'h6745_2301
`define CEH_SHA_H1   32'hEFCD_AB89
`define CEH_SHA_H2   32'h98BA_DCFE
`define CEH_SHA_H3   32'h1032_5476
`define CEH_SHA_H4   32'hC3D2_E1F0
`define CEH_SHA_K0   32'h5A82_7999
`define CEH_SHA_K1   32'h6ED9_EBA1
`define CEH_SHA_K2   32'h8F1B_BCDC
`define CEH_SHA_K3   32'hCA62_C1D6
`define CEH_SHA_LAST 7'h4F
`define CEH_PAD_MARK 8'h80
`define CEH_LEN_POS  6'h38
`define CEH_BLK_END  6'h3F
`endif

// file: rtl/ceh_sha1_core.v
/*
 * sha-1 compression of one 512-bit block, one round per clock.
 * assumes blockIn and hIn stay stable from start until done.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ceh_map.vh"
module ceh_sha1_core (
   input  wire         clk_sys,
   input  wire         resetn,
   input  wire         start,
   input  wire [511:0] blockIn,
   input  wire [159:0] hIn,
   output reg          done,
   output reg  [159:0] hOut
);
   reg [511:0] w_q;
   reg [31:0]  a_q, b_q, c_q, d_q, e_q;
   reg [6:0]   rnd_q;
   reg         run_q;
   reg         fin_q;
   reg [31:0]  f;
   reg [31:0]  k;
   wire [31:0] wX;
   wire [31:0] wNew;
   wire [31:0] tmp;
   // ****************************************************************
   // round function
   // ****************************************************************
   always @* begin
      if (rnd_q < 7'd20) begin
         f = (b_q & c_q) | (~b_q & d_q);
         k = `CEH_SHA_K0;
      end else if (rnd_q < 7'd40) begin
         f = b_q ^ c_q ^ d_q;
         k = `CEH_SHA_K1;
      end else if (rnd_q < 7'd60) begin
         f = (b_q & c_q) | (b_q & d_q) | (c_q & d_q);
         k = `CEH_SHA_K2;
      end else begin
         f = b_q ^ c_q ^ d_q;
         k = `CEH_SHA_K3;
      end
   end
   // window holds w[t..t+15]; w[t] sits in the top word
   assign wX   = w_q[95:64] ^ w_q[255:224] ^ w_q[447:416] ^ w_q[511:480];
   assign wNew = {wX[30:0], wX[31]};
   assign tmp  = {a_q[26:0], a_q[31:27]} + f + e_q + k + w_q[511:480];
   // ****************************************************************
   // round sequencing
   // ****************************************************************
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         w_q   <= 512'h0;
         a_q   <= 32'h0;
         b_q   <= 32'h0;
         c_q   <= 32'h0;
         d_q   <= 32'h0;
         e_q   <= 32'h0;
         rnd_q <= 7'h0;
         run_q <= 1'b0;
         fin_q <= 1'b0;
         done  <= 1'b0;
         hOut  <= 160'h0;
      end else begin
         done  <= 1'b0;
         fin_q <= 1'b0;
         if (start) begin
            w_q   <= blockIn;
            a_q   <= hIn[159:128];
            b_q   <= hIn[127:96];
            c_q   <= hIn[95:64];
            d_q   <= hIn[63:32];
            e_q   <= hIn[31:0];
            rnd_q <= 7'h0;
            run_q <= 1'b1;
         end else if (run_q) begin
            e_q   <= d_q;
            d_q   <= c_q;
            c_q   <= {b_q[1:0], b_q[31:2]};
            b_q   <= a_q;
            a_q   <= tmp;
            w_q   <= {w_q[479:0], wNew};
            rnd_q <= rnd_q + 7'd1;
            if (rnd_q == `CEH_SHA_LAST) begin
               run_q <= 1'b0;
               fin_q <= 1'b1;
            end
         end
         if (fin_q) begin
            hOut <= {hIn[159:128] + a_q, hIn[127:96] + b_q, hIn[95:64] + c_q,
                     hIn[63:32] + d_q, hIn[31:0] + e_q};
            done <= 1'b1;
         end
      end
   end
endmodule // ceh_sha1_core
`default_nettype wire

// file: dv/ceh_hash_unit_monitor.sv
/* checker of the hash unit: grant choice, result pulse and mismatch flag.
   assumes a bind into ceh_hash_unit and one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module ceh_hash_monitor #(
   parameter CHANNELS = 4,
   parameter PRIO_W   = 2
) (
   input wire logic                       clk_sys,
   input wire logic                       resetn,
   input wire logic [CHANNELS-1:0]        chReq,
   input wire logic [CHANNELS*PRIO_W-1:0] chPrio,
   input wire logic                       cmdUseSha,
   input wire logic                       cmdCheck,
   input wire logic [159:0]               refValue,
   input wire logic                       dataValid,
   input wire logic                       dataReady,
   input wire logic                       dataLast,
   input wire logic [CHANNELS-1:0]        chGrant,
   input wire logic                       sigValid,
   input wire logic [159:0]               sigData,
   input wire logic [CHANNELS-1:0]        sigChan,
   input wire logic                       mismatchIrq
);
   // ********
   // helpers
   // ********
   logic [CHANNELS-1:0] win;
   logic [PRIO_W-1:0]   bestP;
   logic                jobSha_q;
   logic                jobChk_q;
   logic [159:0]        jobRef_q;
   logic                refDiff;
   logic                lastIn;
   // scan from the top so that a tie falls to the lower index
   always_comb begin
      win   = '0;
      bestP = '0;
      for (int k = CHANNELS - 1; k >= 0; k--) begin
         if (chReq[k] && (win == '0 || chPrio[k*PRIO_W+:PRIO_W] >= bestP)) begin
            win    = '0;
            win[k] = 1'b1;
            bestP  = chPrio[k*PRIO_W+:PRIO_W];
         end
      end
   end
   // command only counts at the grant decision, so follow it while idle
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         jobSha_q <= 1'b0;
         jobChk_q <= 1'b0;
         jobRef_q <= '0;
      end else if (chGrant == '0) begin
         jobSha_q <= cmdUseSha;
         jobChk_q <= cmdCheck;
         jobRef_q <= refValue;
      end
   end
   assign refDiff = jobSha_q ? sigData != jobRef_q
                             : sigData[31:0] != jobRef_q[31:0];
   assign lastIn  = dataValid && dataReady && dataLast;
   // ********
   // properties
   // ********
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   property p_winner; $rose(|chGrant) |-> chGrant == $past(win); endproperty
   a_winner: assert property (p_winner) else $error("grant order");
   property p_owner; sigValid |-> sigChan == $past(chGrant); endproperty
   a_owner: assert property (p_owner) else $error("result channel");
   property p_pulse; sigValid |=> !sigValid; endproperty
   a_pulse: assert property (p_pulse) else $error("result pulse");
   property p_irqSig; mismatchIrq |-> sigValid; endproperty
   a_irqSig: assert property (p_irqSig) else $error("stray flag");
   property p_irqCause; sigValid |-> mismatchIrq == (jobChk_q && refDiff);
   endproperty
   a_irqCause: assert property (p_irqCause) else $error("flag value");
   property p_crcUpper; sigValid && !jobSha_q |-> sigData[159:32] == '0;
   endproperty
   a_crcUpper: assert property (p_crcUpper) else $error("crc width");
   property p_padStall; lastIn |=> !dataReady; endproperty
   a_padStall: assert property (p_padStall) else $error("pad intake");
   property p_crcEnd; lastIn && !jobSha_q |-> ##[1:8] sigValid; endproperty
   a_crcEnd: assert property (p_crcEnd) else $error("crc late");
   property p_shaEnd; lastIn && jobSha_q |-> ##[80:400] sigValid; endproperty
   a_shaEnd: assert property (p_shaEnd) else $error("digest late");
   cover property (sigValid && mismatchIrq);
   cover property ($rose(|chGrant) && $countones(chReq) > 1);
   cover property (sigValid && jobSha_q);
   cover property (jobSha_q && $rose(dataReady) && $past(|chGrant));
endmodule // ceh_hash_monitor
bind ceh_hash_unit ceh_hash_monitor #(
   .CHANNELS(CHANNELS), .PRIO_W(PRIO_W)
) i_mon (
   .clk_sys(clk_sys), .resetn(resetn), .chReq(chReq), .chPrio(chPrio),
   .cmdUseSha(cmdUseSha), .cmdCheck(cmdCheck), .refValue(refValue),
   .dataValid(dataValid), .dataReady(dataReady), .dataLast(dataLast),
   .chGrant(chGrant), .sigValid(sigValid), .sigData(sigData),
   .sigChan(sigChan), .mismatchIrq(mismatchIrq)
);
`default_nettype wire

// file: dv/ceh_chan_model.sv
/* channel side of the hash unit: request, command and byte stream.
   assumes the bench seeds the random source and fills msg first. */
`timescale 1ns/1ps
`default_nettype none
module ceh_chan_model (
   input  wire logic         clk_sys,
   input  wire logic [3:0]   chGrant,
   input  wire logic         dataReady,
   output var  logic [3:0]   chReq,
   output var  logic [7:0]   chPrio,
   output var  logic         cmdUseSha,
   output var  logic         cmdCheck,
   output var  logic [159:0] refValue,
   output var  logic         dataValid,
   output var  logic [7:0]   dataByte,
   output var  logic         dataLast
);
   logic [7:0] msg[$];
   logic       slow = 1'b0;
   initial begin
      {chReq, chPrio, cmdUseSha, cmdCheck, refValue} = '0;
      {dataValid, dataByte, dataLast} = '0;
   end
   // released byte lines show the inverse so stale data never looks valid
   task automatic serve(input logic [3:0] r, input logic [7:0] p,
                        input logic s, c, input logic [159:0] v);
      logic [3:0] g;
      do @(posedge clk_sys); while (chGrant != 4'h0);
      #1 chPrio = p;
      cmdUseSha = s;
      cmdCheck  = c;
      refValue  = v;
      chReq     = r;
      while (chReq != 4'h0) begin
         g = chGrant & chReq;
         while (g == 4'h0) begin
            @(posedge clk_sys);
            g = chGrant & chReq;
         end
         for (int i = 0; i < msg.size(); i++) begin
            if (slow && $urandom_range(1) == 1) begin
               #1 dataValid = 1'b0;
               dataByte = ~dataByte;
               @(posedge clk_sys);
            end
            #1 dataValid = 1'b1;
            dataByte = msg[i];
            dataLast = (i == msg.size() - 1);
            do @(posedge clk_sys); while (dataReady !== 1'b1);
         end
         #1 dataValid = 1'b0;
         dataLast = 1'b0;
         dataByte = ~dataByte;
         chReq    = chReq & ~g;
      end
   endtask
endmodule // ceh_chan_model
`default_nettype wire

// file: dv/tb_top.sv
/* top bench of the hash unit: crc, sha-1, reference check, arbitration.
   assumes the channel model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   typedef struct {logic [3:0] ch; logic [159:0] d; logic irq;} ceh_exp_t;
   logic         clk_sys = 1'b0;
   logic         resetn  = 1'b0;
   logic [3:0]   chReq, chGrant, sigChan;
   logic [7:0]   chPrio, dataByte;
   logic         cmdUseSha, cmdCheck, dataValid, dataLast;
   logic         dataReady, sigValid, mismatchIrq;
   logic [159:0] refValue, sigData, dg;
   logic [31:0]  rr;
   logic [7:0]   bytes[$];
   ceh_exp_t     expQ[$];
   ceh_exp_t     got;
   int           err_total = 0;
   int           compares  = 0;
   int           cyc       = 0;
   always #12.5 clk_sys = ~clk_sys;
   ceh_hash_unit i_dut (
      .clk_sys(clk_sys), .resetn(resetn), .chReq(chReq), .chPrio(chPrio),
      .cmdUseSha(cmdUseSha), .cmdCheck(cmdCheck), .refValue(refValue),
      .dataValid(dataValid), .dataByte(dataByte), .dataLast(dataLast),
      .chGrant(chGrant), .dataReady(dataReady), .sigValid(sigValid),
      .sigData(sigData), .sigChan(sigChan), .mismatchIrq(mismatchIrq)
   );
   ceh_chan_model i_chan (
      .clk_sys(clk_sys), .chGrant(chGrant), .dataReady(dataReady),
      .chReq(chReq), .chPrio(chPrio), .cmdUseSha(cmdUseSha),
      .cmdCheck(cmdCheck), .refValue(refValue), .dataValid(dataValid),
      .dataByte(dataByte), .dataLast(dataLast)
   );
   task automatic chk(input logic bad, input string m);
      compares++;
      if (bad !== 1'b0) begin
         err_total++;
         $display("Error %0t: %s", $time, m);
      end
   endtask
   task automatic stop_test();
      $display("errors %0d of %0d compares", err_total, compares);
      if (err_total == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   function automatic logic [31:0] crcOf();
      logic [31:0] c;
      logic [7:0]  q[$];
      c = 32'hFFFF_FFFF;
      q = bytes;
      while (q.size() % 4 != 0) q.push_back(8'h00);
      foreach (q[i]) begin
         c = c ^ {24'h0, q[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ 32'hEDB8_8320 : c >> 1;
      end
      return ~c;
   endfunction
   task automatic setStr(input string s);
      bytes.delete();
      for (int i = 0; i < s.len(); i++) bytes.push_back(s[i]);
   endtask
   // expected owners follow the priority order, ties to the lower index
   task automatic job(input logic [3:0] r, input logic [7:0] p,
                      input logic s, c, ok, input logic [159:0] sh);
      ceh_exp_t   x;
      logic [3:0] left;
      int         b;
      x.d   = s ? sh : {128'h0, crcOf()};
      x.irq = c & ~ok;
      left  = r;
      while (left != 4'h0) begin
         b = 0;
         for (int k = 3; k >= 0; k--)
            if (left[k] && (!left[b] || p[2*k+:2] >= p[2*b+:2])) b = k;
         x.ch    = 4'h0;
         x.ch[b] = 1'b1;
         expQ.push_back(x);
         left[b] = 1'b0;
      end
      i_chan.msg = bytes;
      i_chan.serve(r, p, s, c, ok ? x.d : x.d ^ 160'h1);
   endtask
   always @(posedge clk_sys) begin
      if (sigValid === 1'b1) begin
         if (expQ.size() == 0)
            chk(1'b1, "unexpected signature");
         else begin
            got = expQ.pop_front();
            chk(sigChan !== got.ch, "channel");
            chk(sigData !== got.d, "signature");
            chk(mismatchIrq !== got.irq, "mismatch flag");
         end
      end
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         $display("Error %0t: timeout", $time);
         stop_test();
      end
   end
   initial begin
      void'($urandom(32'hdfa2));
      repeat (5) @(posedge clk_sys);
      #1 resetn = 1'b1;
      for (int n = 1; n <= 8; n++) begin
         bytes.delete();
         repeat (n) bytes.push_back(8'($urandom_range(255)));
         i_chan.slow = n[0];
         rr = $urandom;
         job(4'(1 << rr[1:0]), rr[15:8], 1'b0, rr[2], rr[3], '0);
      end
      setStr("ab");
      job(4'hF, 8'($urandom), 1'b0, 1'b1, 1'b1, '0);
      job(4'hA, 8'h00, 1'b0, 1'b0, 1'b0, '0);
      setStr("abc");
      dg = 160'hA999_3E36_4706_816A_BA3E_2571_7850_C26C_9CD0_D89D;
      job(4'h4, 8'h40, 1'b1, 1'b1, 1'b1, dg);
      setStr("abcdbcdecdefdefgefghfghighijhijkijkljklmklmnlmnomnopnopq");
      i_chan.slow = 1'b1;
      dg = 160'h8498_3E44_1C3B_D26E_BAAE_4AA1_F951_29E5_E546_70F1;
      job(4'h1, 8'h00, 1'b1, 1'b1, 1'b0, dg);
      // two data blocks: intake stalls at byte 64 and resumes by itself
      bytes.delete();
      for (int g = 0; g < 14; g++)
         for (int j = 0; j < 8; j++) bytes.push_back(8'("a" + g + j));
      dg = 160'hA49B_2446_A02C_645B_F419_F995_B670_9125_3A04_A259;
      job(4'h2, 8'h0C, 1'b1, 1'b1, 1'b1, dg);
      for (int w = 0; w < 2000 && expQ.size() != 0; w++) @(posedge clk_sys);
      chk(expQ.size() != 0, "signature missing");
      stop_test();
   end
endmodule // tb_top
`default_nettype wire
